// *** wdt_evt_regs.sv ***
`timescale 1ns/100ps
`default_nettype none

module wdt_evt_regs import wdt_pkg::*; (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [EVT_W-1:0] evt,
	input  wire logic             rd_clr,
	input  wire logic             mask_wr,
	input  wire logic [EVT_W-1:0] mask_wdata,
	output logic      [EVT_W-1:0] status,
	output logic      [EVT_W-1:0] mask,
	output logic                  irq
);

	logic [EVT_W-1:0] status_next;
	logic [EVT_W-1:0] mask_next;
	logic             irq_next;

	// an event in the clearing cycle survives the read
	always_comb begin
		status_next = (rd_clr ? '0 : status) | evt;
		mask_next = mask_wr ? mask_wdata : mask;
		irq_next = |(status_next & mask_next);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= '0;
			mask <= MASK_RST;
			irq <= 1'b0;
		end else begin
			status <= status_next;
			mask <= mask_next;
			irq <= irq_next;
		end
	end

	AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
		irq == |(status & mask))
		else $error("interrupt level disagrees with status and mask");

endmodule : wdt_evt_regs

`default_nettype wire

// *** wdt_pkg.sv ***
package wdt_pkg;

	localparam int unsigned CNT_W         = 16;
	localparam int unsigned DATA_W        = 32;
	localparam int unsigned EVT_W         = 2;

	// prescaler ratios (system clock cycles per counter tick)
	localparam int unsigned FINE_DIV_DEF   = 256;
	localparam int unsigned COARSE_DIV_DEF = 16384;

	// span at the reference system clock
	localparam int unsigned SPAN_FSYS_MHZ   = 80;
	localparam int unsigned MIN_INTERVAL_NS = 3200;
	localparam int unsigned MIN_CYCLES      =
		MIN_INTERVAL_NS * SPAN_FSYS_MHZ / 1000;

	// default interval after power-up at a 10 MHz system clock
	localparam int unsigned DEF_FSYS_MHZ    = 10;
	localparam int unsigned DEF_INTERVAL_NS = 6500000;
	localparam int unsigned DEF_CYCLES      =
		DEF_INTERVAL_NS / 1000 * DEF_FSYS_MHZ;
	localparam int unsigned DEF_TICKS       =
		(DEF_CYCLES + FINE_DIV_DEF - 1) / FINE_DIV_DEF;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_RELOAD = 8'h04;
	localparam logic [7:0] OFF_COUNT  = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_MASK   = 8'h10;

	// control register fields
	localparam int unsigned CTRL_FINE_BIT = 0;
	localparam int unsigned CTRL_SVC_BIT  = 8;
	localparam int unsigned CTRL_DIS_BIT  = 9;
	localparam int unsigned CTRL_EN_BIT   = 10;

	// status register fields
	localparam int unsigned ST_WARN_BIT   = 0;
	localparam int unsigned ST_RESET_BIT  = 1;
	localparam int unsigned ST_ON_BIT     = 8;

	// reset values
	localparam logic             FINE_RST   = 1'b1;
	localparam logic [CNT_W-1:0] RELOAD_RST =
		CNT_W'(32'h0001_0000 - DEF_TICKS);
	localparam logic [CNT_W-1:0] CNT_MAX    = 16'hFFFF;
	localparam logic [EVT_W-1:0] MASK_RST   = 2'h3;

	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_WARN  = 2'b01,
		ST_RESET = 2'b10
	} wdt_state_t;

	// commands from the instruction path, one-cycle pulses
	typedef struct packed {
		logic service;
		logic watchdog_disable_cmd;
		logic watchdog_enable_cmd;
	} wdt_cmd_t;

endpackage : wdt_pkg

// *** wdt_prescaler.sv ***
`timescale 1ns/100ps
`default_nettype none

module wdt_prescaler import wdt_pkg::*; #(
	parameter int unsigned FINE_DIV   = FINE_DIV_DEF,
	parameter int unsigned COARSE_DIV = COARSE_DIV_DEF,
	parameter int unsigned PS_W       = $clog2(COARSE_DIV)
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic run,
	input  wire logic clear,
	input  wire logic fine_sel,
	output logic      tick
);

	if (FINE_DIV < 2 || COARSE_DIV <= FINE_DIV || PS_W < $clog2(COARSE_DIV))
		$error("prescaler ratios unusable");

	logic [PS_W-1:0] ps_reg;
	logic [PS_W-1:0] ps_next;
	logic            fine_cur_reg;
	logic            fine_cur_next;
	logic [PS_W-1:0] lim;

	// selection is taken at each period start, so a change never strands
	// the count above a smaller limit
	always_comb begin
		lim = fine_cur_reg ? PS_W'(FINE_DIV - 1) : PS_W'(COARSE_DIV - 1);
		tick = run && (ps_reg == lim);
		ps_next = ps_reg;
		fine_cur_next = fine_cur_reg;
		if (clear) begin
			ps_next = '0;
			fine_cur_next = fine_sel;
		end else if (tick) begin
			ps_next = '0;
			fine_cur_next = fine_sel;
		end else if (run) begin
			ps_next = ps_reg + PS_W'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ps_reg <= '0;
			fine_cur_reg <= FINE_RST;
		end else begin
			ps_reg <= ps_next;
			fine_cur_reg <= fine_cur_next;
		end
	end

	// independent run-cycle count since the period start
	logic [PS_W:0] gap_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_reg <= '0;
		end else if (clear || tick) begin
			gap_reg <= '0;
		end else if (run) begin
			gap_reg <= gap_reg + (PS_W+1)'(1);
		end
	end

	AST_TICK_GAP: assert property (@(posedge pclk) disable iff (!presetn)
		tick |-> (gap_reg == (fine_cur_reg ? (PS_W+1)'(FINE_DIV - 1)
			: (PS_W+1)'(COARSE_DIV - 1))))
		else $error("prescaler tick period wrong");

endmodule : wdt_prescaler

`default_nettype wire

// *** wdt_timer.sv ***
// Chosen here: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none

module wdt_timer import wdt_pkg::*; #(
	parameter int unsigned COARSE_DIV = COARSE_DIV_DEF,
	parameter int unsigned FINE_DIV   = FINE_DIV_DEF,
	parameter int unsigned ADDR_W     = 8
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire wdt_cmd_t          cmd,
	output logic                   irq,
	output logic                   prewarn,
	output logic                   reset_req
);

	// elaboration checks
	if (ADDR_W < 5)
		$error("ADDR_W too small for the register map");
	if (FINE_DIV < 2 || COARSE_DIV <= FINE_DIV)
		$error("prescaler ratios unusable");
	if (FINE_DIV_DEF != MIN_CYCLES)
		$error("fine ratio does not give the shortest interval");

	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [7:0] off);
		hit = (a == ADDR_W'(off));
	endfunction : hit

	// ---------------- bus decode ----------------
	logic setup_rd;
	logic acc;
	logic acc_wr;
	logic acc_rd;
	logic mapped;
	logic wr_ctrl;
	logic wr_reload;
	logic wr_mask;
	logic rd_status;

	always_comb begin
		setup_rd = psel && !penable && !pwrite;
		acc = psel && penable;
		acc_wr = acc && pwrite;
		acc_rd = acc && !pwrite;
		if (hit(paddr, OFF_CTRL)) begin
			mapped = 1'b1;
		end else if (hit(paddr, OFF_RELOAD)) begin
			mapped = 1'b1;
		end else if (hit(paddr, OFF_COUNT)) begin
			mapped = 1'b1;
		end else if (hit(paddr, OFF_STATUS)) begin
			mapped = 1'b1;
		end else if (hit(paddr, OFF_MASK)) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
		wr_ctrl = acc_wr && hit(paddr, OFF_CTRL);
		wr_reload = acc_wr && hit(paddr, OFF_RELOAD);
		wr_mask = acc_wr && hit(paddr, OFF_MASK);
		rd_status = acc_rd && hit(paddr, OFF_STATUS);
		// zero wait states; the read word is prepared in the setup cycle
		pready = 1'b1;
		pslverr = acc && !mapped;
	end

	// ---------------- commands ----------------
	logic svc;
	logic dis;
	logic ena;

	// instruction path and software strobes act alike
	always_comb begin
		svc = cmd.service || (wr_ctrl && pwdata[CTRL_SVC_BIT]);
		dis = cmd.watchdog_disable_cmd || (wr_ctrl && pwdata[CTRL_DIS_BIT]);
		ena = cmd.watchdog_enable_cmd || (wr_ctrl && pwdata[CTRL_EN_BIT]);
	end

	// ---------------- configuration ----------------
	logic             fine_reg;
	logic             fine_next;
	logic [CNT_W-1:0] reload_reg;
	logic [CNT_W-1:0] reload_next;

	always_comb begin
		fine_next = wr_ctrl ? pwdata[CTRL_FINE_BIT] : fine_reg;
		reload_next = wr_reload ? pwdata[CNT_W-1:0] : reload_reg;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fine_reg <= FINE_RST;
			reload_reg <= RELOAD_RST;
		end else begin
			fine_reg <= fine_next;
			reload_reg <= reload_next;
		end
	end

	// ---------------- counter and sequence ----------------
	logic             enabled_reg;
	logic             enabled_next;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	wdt_state_t       st_reg;
	wdt_state_t       st_next;
	logic             tick;
	logic             run;
	logic             svc_ok;
	logic             ovf;

	wdt_prescaler #(
		.FINE_DIV   (FINE_DIV),
		.COARSE_DIV (COARSE_DIV)
	) i_wdt_prescaler (
		.pclk     (pclk),
		.presetn  (presetn),
		.run      (run),
		.clear    (svc_ok),
		.fine_sel (fine_reg),
		.tick     (tick)
	);

	always_comb begin
		// enable wins if both commands meet in one cycle
		enabled_next = enabled_reg;
		if (dis) begin
			enabled_next = 1'b0;
		end
		if (ena) begin
			enabled_next = 1'b1;
		end
		// once the reset request stands, servicing cannot withdraw it
		run = enabled_reg && (st_reg != ST_RESET);
		svc_ok = svc && (st_reg != ST_RESET);
		cnt_next = cnt_reg;
		st_next = st_reg;
		ovf = 1'b0;
		if (svc_ok) begin
			cnt_next = reload_reg;
			st_next = ST_RUN;
		end else if (tick) begin
			if (cnt_reg == CNT_MAX) begin
				ovf = 1'b1;
				cnt_next = reload_reg;
				case (st_reg)
					ST_RUN: begin
						st_next = ST_WARN;
					end
					ST_WARN: begin
						st_next = ST_RESET;
					end
					default: begin
						st_next = st_reg;
					end
				endcase
			end else begin
				cnt_next = cnt_reg + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enabled_reg <= 1'b1;
			cnt_reg <= RELOAD_RST;
			st_reg <= ST_RUN;
		end else begin
			enabled_reg <= enabled_next;
			cnt_reg <= cnt_next;
			st_reg <= st_next;
		end
	end

	always_comb begin
		prewarn = (st_reg != ST_RUN);
		reset_req = (st_reg == ST_RESET);
	end

	// ---------------- events ----------------
	logic [EVT_W-1:0] evt;
	logic [EVT_W-1:0] status;
	logic [EVT_W-1:0] mask;

	always_comb begin
		evt = '0;
		evt[ST_WARN_BIT] = ovf && (st_reg == ST_RUN);
		evt[ST_RESET_BIT] = ovf && (st_reg == ST_WARN);
		// a bit set after the read word was taken must survive the clear
		if (rd_status) begin
			evt = evt | (status & ~prdata[EVT_W-1:0]);
		end
	end

	wdt_evt_regs i_wdt_evt_regs (
		.pclk       (pclk),
		.presetn    (presetn),
		.evt        (evt),
		.rd_clr     (rd_status),
		.mask_wr    (wr_mask),
		.mask_wdata (pwdata[EVT_W-1:0]),
		.status     (status),
		.mask       (mask),
		.irq        (irq)
	);

	// ---------------- read data ----------------
	logic [DATA_W-1:0] rd_word;
	logic [DATA_W-1:0] prdata_next;

	always_comb begin
		rd_word = '0;
		if (hit(paddr, OFF_CTRL)) begin
			rd_word[CTRL_FINE_BIT] = fine_reg;
		end else if (hit(paddr, OFF_RELOAD)) begin
			rd_word[CNT_W-1:0] = reload_reg;
		end else if (hit(paddr, OFF_COUNT)) begin
			rd_word[CNT_W-1:0] = cnt_reg;
		end else if (hit(paddr, OFF_STATUS)) begin
			rd_word[EVT_W-1:0] = status;
			rd_word[ST_ON_BIT] = enabled_reg;
		end else if (hit(paddr, OFF_MASK)) begin
			rd_word[EVT_W-1:0] = mask;
		end
		prdata_next = setup_rd ? rd_word : prdata;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else begin
			prdata <= prdata_next;
		end
	end

	// ---------------- checks ----------------
	logic first_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_reg <= 1'b1;
		end else begin
			first_reg <= 1'b0;
		end
	end

	default clocking chk_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_first_ovf;
		(st_reg == ST_RUN) && ovf;
	endsequence

	sequence s_second_ovf;
		(st_reg == ST_WARN) && ovf;
	endsequence

	AST_BOOT_ENABLED: assert property (
		first_reg |-> enabled_reg && run && cnt_reg == reload_reg)
		else $error("watchdog not running after reset");

	AST_BOOT_DEFAULTS: assert property (
		first_reg |-> fine_reg && reload_reg == RELOAD_RST)
		else $error("reset defaults wrong");

	// a tick in the command cycle may still land; the freeze shows a cycle on
	AST_DISABLE_STOPS: assert property (
		(dis && !ena) |=> !enabled_reg && !run
			##1 ($stable(cnt_reg) || $past(svc_ok)))
		else $error("disable did not stop the counter");

	AST_ENABLE_RESUMES: assert property (
		ena |=> enabled_reg)
		else $error("enable did not restart counting");

	AST_WARN_FIRST: assert property (
		s_first_ovf |=> prewarn && !reset_req ##0 status[ST_WARN_BIT])
		else $error("first overflow did not prewarn");

	AST_RESET_AFTER_WARN: assert property (
		s_second_ovf |=> reset_req && prewarn [*2])
		else $error("reset request missing after prewarning");

	AST_NO_EARLY_RESET: assert property (
		$rose(reset_req) |-> $past(prewarn))
		else $error("reset request without prewarning");

	AST_RESET_HOLDS: assert property (
		reset_req |=> reset_req)
		else $error("reset request withdrawn before reset");

	AST_COUNT_STEP: assert property (
		(tick && !svc_ok && cnt_reg != CNT_MAX)
			|=> cnt_reg == $past(cnt_reg) + CNT_W'(1))
		else $error("counter did not advance on tick");

	AST_SERVICE_RELOAD: assert property (
		svc_ok |=> cnt_reg == $past(reload_reg) && st_reg == ST_RUN)
		else $error("service did not reload the counter");

	AST_WRAP_OVF: assert property (
		ovf |-> cnt_reg == CNT_MAX ##1 cnt_reg == $past(reload_reg))
		else $error("overflow not at the all-ones count");

endmodule : wdt_timer

`default_nettype wire

// *** wdt_timer_tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module wdt_timer_tb import wdt_pkg::*;;

	localparam int unsigned FDIV = 16;
	localparam int unsigned CDIV = 512;
	localparam int          TOL  = 4;

	logic              pclk    = 1'b0;
	logic              presetn = 1'b0;
	logic              psel    = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite  = 1'b0;
	logic [7:0]        paddr   = 8'h00;
	logic [DATA_W-1:0] pwdata  = 32'h0000_0000;
	logic [DATA_W-1:0] prdata;
	logic              pready;
	logic              pslverr;
	wdt_cmd_t          cmd     = 3'h0;
	logic              irq;
	logic              prewarn;
	logic              reset_req;
	int                errors     = 0;
	int                n_compared = 0;
	int                cycles     = 0;

	wdt_timer #(
		.COARSE_DIV (CDIV),
		.FINE_DIV   (FDIV),
		.ADDR_W     (8)
	) i_wdt_timer (
		.pclk      (pclk),
		.presetn   (presetn),
		.psel      (psel),
		.penable   (penable),
		.pwrite    (pwrite),
		.paddr     (paddr),
		.pwdata    (pwdata),
		.prdata    (prdata),
		.pready    (pready),
		.pslverr   (pslverr),
		.cmd       (cmd),
		.irq       (irq),
		.prewarn   (prewarn),
		.reset_req (reset_req)
	);

	always #2.5 pclk = ~pclk;

	task automatic end_of_test();
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_of_test

	// the slowest test needs about a thousand cycles
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			errors++;
			$display("mismatch at %0t: timeout", $time);
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got,
				exp);
		end
	endtask : chk

	task automatic chk_n(input int got, input int exp, input string what);
		n_compared++;
		if (got < exp - TOL || got > exp + TOL) begin
			errors++;
			$display("mismatch at %0t: %s took %0d exp %0d", $time, what,
				got, exp);
		end
	endtask : chk_n

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic err);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0000_0000, r, e);
	endtask : rd

	task automatic pulse(input wdt_cmd_t c);
		@(posedge pclk);
		cmd <= c;
		@(posedge pclk);
		cmd <= 3'h0;
	endtask : pulse

	// counts cycles until prewarn (rq=0) or reset_req (rq=1) is seen high
	task automatic wait_evt(input bit rq, output int n);
		n = 0;
		while (((rq ? reset_req : prewarn) !== 1'b1) && n < 5000) begin
			@(negedge pclk);
			n++;
		end
	endtask : wait_evt

	task automatic do_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask : do_reset

	task automatic t_defaults();
		logic [31:0] r;
		logic [31:0] a;
		logic        e;
		do_reset();
		rd(OFF_CTRL, r);
		chk(r, 32'h0000_0001, "ctrl default");
		rd(OFF_RELOAD, r);
		// 6.5 ms at 10 MHz in ticks of 256 cycles, rounded up
		chk(r, 32'h0001_0000 - (32'd65000 + 32'd255) / 32'd256, "reload");
		rd(OFF_MASK, r);
		chk(r, 32'h0000_0003, "mask default");
		rd(OFF_STATUS, r);
		chk(r, 32'h0000_0100, "enabled after reset");
		rd(OFF_COUNT, a);
		repeat (40) @(posedge pclk);
		rd(OFF_COUNT, r);
		chk(32'(r > a), 32'h0000_0001, "counting after reset");
		wr(OFF_COUNT, 32'h0000_0000);
		rd(OFF_COUNT, r);
		chk(32'(r[15:0] > 16'hFF02), 32'h0000_0001, "count read only");
		apb(1'b0, 8'h14, 32'h0000_0000, r, e);
		chk({31'h0, e}, 32'h0000_0001, "unmapped error");
		chk(r, 32'h0000_0000, "unmapped data");
		chk({31'h0, pready}, 32'h0000_0001, "zero wait state");
		$display("test defaults done");
	endtask : t_defaults

	task automatic t_overflow();
		logic [31:0] r;
		int          n;
		do_reset();
		wr(OFF_RELOAD, 32'h0000_FFFC);
		pulse(3'b100);
		wait_evt(1'b0, n);
		chk_n(n, 4 * FDIV, "prewarn delay");
		chk({31'h0, reset_req}, 32'h0000_0000, "no early reset");
		repeat (2) @(negedge pclk);
		chk({31'h0, irq}, 32'h0000_0001, "irq on prewarn");
		wait_evt(1'b1, n);
		chk_n(n, 4 * FDIV - 2, "reset delay");
		rd(OFF_STATUS, r);
		chk(r, 32'h0000_0103, "both events");
		repeat (3) @(negedge pclk);
		chk({31'h0, irq}, 32'h0000_0000, "irq cleared by read");
		pulse(3'b100);
		repeat (2) @(negedge pclk);
		chk({31'h0, reset_req}, 32'h0000_0001, "service refused");
		$display("test overflow done");
	endtask : t_overflow

	task automatic t_coarse();
		int n;
		do_reset();
		wr(OFF_RELOAD, 32'h0000_FFFE);
		wr(OFF_CTRL, 32'h0000_0000);
		wr(OFF_CTRL, 32'h0000_0100);
		wait_evt(1'b0, n);
		chk_n(n, 2 * CDIV, "coarse interval");
		$display("test coarse done");
	endtask : t_coarse

	task automatic t_disable();
		logic [31:0] r;
		logic [31:0] a;
		do_reset();
		pulse(3'b010);
		rd(OFF_STATUS, r);
		chk(r, 32'h0000_0000, "disabled");
		rd(OFF_COUNT, a);
		repeat (100) @(posedge pclk);
		rd(OFF_COUNT, r);
		chk(r, a, "count frozen");
		pulse(3'b011);
		rd(OFF_STATUS, r);
		chk(r, 32'h0000_0100, "enable wins");
		repeat (40) @(posedge pclk);
		rd(OFF_COUNT, r);
		chk(32'(r > a), 32'h0000_0001, "count resumes");
		wr(OFF_CTRL, 32'h0000_0201);
		rd(OFF_STATUS, r);
		chk(r, 32'h0000_0000, "register disable");
		wr(OFF_CTRL, 32'h0000_0401);
		rd(OFF_STATUS, r);
		chk(r, 32'h0000_0100, "register enable");
		$display("test disable done");
	endtask : t_disable

	task automatic t_service();
		int n;
		do_reset();
		wr(OFF_MASK, 32'h0000_0000);
		wr(OFF_RELOAD, 32'h0000_FFFF);
		pulse(3'b100);
		repeat (10) @(posedge pclk);
		// a stale prescaler would overflow twelve cycles early
		pulse(3'b100);
		@(negedge pclk);
		chk({31'h0, prewarn}, 32'h0000_0000, "serviced in time");
		wait_evt(1'b0, n);
		chk_n(n, FDIV - 1, "one tick after service");
		chk({31'h0, irq}, 32'h0000_0000, "masked irq");
		wr(OFF_MASK, 32'h0000_0001);
		repeat (2) @(negedge pclk);
		chk({31'h0, irq}, 32'h0000_0001, "unmasked irq");
		pulse(3'b100);
		repeat (2) @(negedge pclk);
		chk({31'h0, prewarn}, 32'h0000_0000, "service in warn");
		chk({31'h0, reset_req}, 32'h0000_0000, "no reset request");
		$display("test service done");
	endtask : t_service

	initial begin
		t_defaults();
		t_overflow();
		t_coarse();
		t_disable();
		t_service();
		end_of_test();
	end

endmodule : wdt_timer_tb

`default_nettype wire
